// [dv/rimb_mask_bank_properties.sv]
// Checker on the ports of the receive interrupt mask bank
`timescale 1ns/1ps
`default_nettype none

module rimb_mask_bank_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [rimb_pkg::RIMB_PORTS-1:0] e1_mode,
   input wire rimb_pkg::rimb_regs_t [rimb_pkg::RIMB_PORTS-1:0] rx_status,
   input wire logic [rimb_pkg::RIMB_PORTS-1:0][7:0] rx_interrupt_summary,
   input wire logic interrupt_out_n
);
   import rimb_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // Bus and interrupt properties
   // ----------------------------------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_ready_once: assert property (s_setup |=> s_answer) else $error("ready not one cycle after setup");
   a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("error reply bad");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("read upper bits set");
   a_unmapped_err: assert property (s_setup and paddr == 16'h0294 |=> pslverr) else $error("gap not refused");
   a_int_summary: assert property (interrupt_out_n == (rx_interrupt_summary == '0)) else $error("int vs summary");
   a_quiet_status: assert property (rx_status == '0 |=> rx_interrupt_summary == '0) else $error("summary no cause");
   a_spare_summary: assert property (rx_interrupt_summary[2][7] == 1'b0 && rx_interrupt_summary[2][5] == 1'b0)
      else $error("spare summary bit set");
   a_alarm_upper: assert property (rx_status[0].alarm[3:0] == 4'h0 |=> !rx_interrupt_summary[0][0])
      else $error("alarm upper bits leak");
   a_store_gap: assert property ((rx_status[1].store & 8'hEF) == 8'h00 |=> !rx_interrupt_summary[1][3])
      else $error("store bit 4 leaks");
   a_reset_quiet: assert property ($rose(presetn) |-> interrupt_out_n && rx_interrupt_summary == '0)
      else $error("not masked after reset");
   a_t1_frame_off: assert property (!e1_mode[0] |=> !rx_interrupt_summary[0][1])
      else $error("frame summary set in T1");
   a_write_rdata: assert property (s_setup and pwrite |=> prdata == 32'h0000_0000)
      else $error("write returned read data");
endmodule : rimb_mask_bank_properties

`default_nettype wire

// [dv/rimb_mask_bank_tb_top.sv]
// Self-checking testbench of the receive interrupt mask bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("FAIL %0t got %0h exp %0h", $time, got, exp); end end

module rimb_mask_bank_tb_top;
   import rimb_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic [RIMB_PORTS-1:0] e1_mode = 4'h0;
   rimb_regs_t [RIMB_PORTS-1:0] rx_status = '0;
   logic [RIMB_PORTS-1:0][7:0] rx_interrupt_summary;
   logic interrupt_out_n;
   int n_errors = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic err;
   logic [3:0] strb = 4'h1;
   logic [7:0] offs [6] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA6};
   logic [7:0] vt1 [6] = '{8'h0F, 8'h00, 8'hFF, 8'hEF, 8'h3F, 8'h3F};
   logic [7:0] ve1 [6] = '{8'h0F, 8'h0F, 8'hBB, 8'hEF, 8'h3F, 8'h00};
   int sbit [6] = '{0, 1, 2, 3, 4, 6};

   always #2.5 pclk = ~pclk;

   rimb_mask_bank rimb_mask_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .e1_mode(e1_mode), .rx_status(rx_status),
      .rx_interrupt_summary(rx_interrupt_summary), .interrupt_out_n(interrupt_out_n));

   // ----------------------------------------------------------------
   // Bus access and scenarios
   // ----------------------------------------------------------------
   function automatic logic [15:0] ra(input int p, input int s);
      return 16'(4 * (offs[s] + 32'h0000_0200 * p));
   endfunction : ra

   task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic t_reset();
      for (int p = 0; p < 4; p++) for (int s = 0; s < 6; s++) begin
         apb(1'b0, ra(p, s), 8'h00);
         `CHK(rd, 32'h0000_0000)
      end
   endtask : t_reset

   task automatic t_regs();
      for (int m = 0; m < 2; m++) begin
         e1_mode <= (m == 1) ? 4'hF : 4'h0;
         for (int p = 0; p < 4; p++) for (int s = 0; s < 6; s++) apb(1'b1, ra(p, s), 8'hFF >> p);
         for (int p = 0; p < 4; p++) for (int s = 0; s < 6; s++) begin
            apb(1'b0, ra(p, s), 8'h00);
            `CHK(rd, {24'h00_0000, (8'hFF >> p) & ((m == 1) ? ve1[s] : vt1[s])})
            `CHK(err, 1'b0)
            apb(1'b1, ra(p, s), 8'h00);
         end
      end
   endtask : t_regs

   task automatic t_err();
      logic [15:0] bad [3] = '{16'h0294, 16'h0281, 16'h2280};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, bad[i], 8'hFF);
         `CHK(err, 1'b1)
         apb(1'b0, bad[i], 8'h00);
         `CHK(err, 1'b1)
         `CHK(rd, 32'h0000_0000)
      end
   endtask : t_err

   task automatic t_mode();
      apb(1'b1, ra(2, 2), 8'hFF);
      e1_mode <= 4'h4;
      rx_status[2] <= rimb_regs_t'(48'h44 << 16);
      repeat (3) @(posedge pclk);
      `CHK(interrupt_out_n, 1'b1)
      rx_status[2] <= rimb_regs_t'(48'h80 << 16);
      repeat (3) @(posedge pclk);
      `CHK(interrupt_out_n, 1'b0)
      `CHK(rx_interrupt_summary[2], 8'h04)
      strb <= 4'h0;
      apb(1'b1, ra(2, 2), 8'h00);
      strb <= 4'h1;
      apb(1'b0, ra(2, 2), 8'h00);
      `CHK(rd, 32'h0000_00BB)
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ra(2, 2), 8'h00);
      `CHK(rd, 32'h0000_0000)
      `CHK(interrupt_out_n, 1'b1)
      rx_status[2] <= '0;
   endtask : t_mode

   task automatic t_irq();
      for (int s = 0; s < 6; s++) begin
         e1_mode <= (s == 1) ? 4'hF : 4'h0;
         apb(1'b1, ra(s % 4, s), 8'h01);
         rx_status[s % 4] <= rimb_regs_t'(48'hFE << (8 * s));
         repeat (3) @(posedge pclk);
         `CHK(interrupt_out_n, 1'b1)
         `CHK(rx_interrupt_summary[s % 4], 8'h00)
         rx_status[s % 4] <= rimb_regs_t'(48'h01 << (8 * s));
         repeat (3) @(posedge pclk);
         `CHK(interrupt_out_n, 1'b0)
         `CHK(rx_interrupt_summary[s % 4], 8'h01 << sbit[s])
         apb(1'b1, ra(s % 4, s), 8'h00);
         repeat (3) @(posedge pclk);
         `CHK(interrupt_out_n, 1'b1)
         rx_status[s % 4] <= '0;
      end
   endtask : t_irq

   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_err();
      t_irq();
      t_mode();
      stop_test();
   end

   initial begin
      #50us;
      n_errors++;
      stop_test();
   end
endmodule : rimb_mask_bank_tb_top

bind rimb_mask_bank rimb_mask_bank_properties rimb_mask_bank_properties_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .e1_mode(e1_mode), .rx_status(rx_status),
   .rx_interrupt_summary(rx_interrupt_summary), .interrupt_out_n(interrupt_out_n));

`default_nettype wire

// [logic/rimb_apb_slave.sv]
// APB slave front end of the receive interrupt mask bank
`timescale 1ns/1ps
`default_nettype none

module rimb_apb_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [7:0] rd_byte,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output rimb_pkg::rimb_access_t access,
   output rimb_pkg::rimb_write_t wr
);
   import rimb_pkg::*;

   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic setup;
   logic [31:0] nxt_prdata;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign setup = psel & ~penable;
   assign access = rimb_decode(paddr);
   assign nxt_prdata = (setup & ~pwrite & access.hit) ? {24'h00_0000, rd_byte} : RIMB_RDATA_RST;
   assign wr.valid = psel & penable & pready_ff & pwrite & access.hit & pstrb[0];
   assign wr.port = access.port;
   assign wr.slot = access.slot;
   assign wr.data = pwdata[7:0];

   // ----------------------------------------------------------------
   // Answer flops: one access cycle, no wait states
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= RIMB_RDATA_RST;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup & ~access.hit;
         prdata_ff <= nxt_prdata;
      end
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

endmodule : rimb_apb_slave

`default_nettype wire

// [logic/rimb_mask_bank.sv]
// Receive interrupt mask bank: four ports of mask registers gating latched events
`timescale 1ns/1ps
`default_nettype none

module rimb_mask_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [rimb_pkg::RIMB_PORTS-1:0] e1_mode,
   input wire rimb_pkg::rimb_regs_t [rimb_pkg::RIMB_PORTS-1:0] rx_status,
   output logic [rimb_pkg::RIMB_PORTS-1:0][7:0] rx_interrupt_summary,
   output logic interrupt_out_n
);
   import rimb_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   rimb_access_t access;
   rimb_write_t wr;
   logic [7:0] rd_byte;
   logic [7:0] mask_ff [RIMB_PORTS][RIMB_SLOTS];
   logic [7:0] eff_mask [RIMB_PORTS][RIMB_SLOTS];
   logic [RIMB_PORTS-1:0][7:0] nxt_summary;
   logic [RIMB_PORTS-1:0] port_pending;
   logic [RIMB_PORTS-1:0][7:0] summary_ff;
   logic int_n_ff;
   logic nxt_int_n;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   rimb_apb_slave rimb_apb_slave_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .rd_byte(rd_byte),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .access(access),
      .wr(wr)
   );

   // Read back only the bits that exist in the port's mode
   assign rd_byte = eff_mask[access.port][access.slot];

   // ----------------------------------------------------------------
   // Mask storage, one byte per slot per port
   // ----------------------------------------------------------------
   for (genvar gp = 0; gp < RIMB_PORTS; gp++) begin : g_port
      for (genvar gs = 0; gs < RIMB_SLOTS; gs++) begin : g_slot
         logic [7:0] valid;
         logic hit;
         logic [7:0] nxt_mask;

         assign valid = rimb_valid_bits(3'(gs), e1_mode[gp]);
         assign hit = wr.valid && wr.port == 2'(gp) && wr.slot == 3'(gs);
         assign nxt_mask = hit ? (wr.data & valid) : mask_ff[gp][gs];
         assign eff_mask[gp][gs] = mask_ff[gp][gs] & valid;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mask_ff[gp][gs] <= RIMB_MASK_RST;
            end else begin
               mask_ff[gp][gs] <= nxt_mask;
            end
         end
      end

      // --------------------------------------------------------------
      // Alarm enables
      // --------------------------------------------------------------
      wire logic remote_alarm_detect_en = eff_mask[gp][RIMB_SLOT_ALARM][3];
      wire logic alarm_signal_detect_en = eff_mask[gp][RIMB_SLOT_ALARM][2];
      wire logic signal_loss_detect_en = eff_mask[gp][RIMB_SLOT_ALARM][1];
      wire logic frame_loss_detect_en = eff_mask[gp][RIMB_SLOT_ALARM][0];

      // --------------------------------------------------------------
      // E1 frame event enables
      // --------------------------------------------------------------
      wire logic sig_all_ones_en = eff_mask[gp][RIMB_SLOT_FRAME][3];
      wire logic sig_all_zeros_en = eff_mask[gp][RIMB_SLOT_FRAME][2];
      wire logic crc4_multiframe_en = eff_mask[gp][RIMB_SLOT_FRAME][1];
      wire logic align_frame_en = eff_mask[gp][RIMB_SLOT_FRAME][0];

      // --------------------------------------------------------------
      // Code and clock enables, shared between both layouts
      // --------------------------------------------------------------
      wire logic rx_clock_loss_clear_en = eff_mask[gp][RIMB_SLOT_CODE][7];
      wire logic rx_clock_loss_detect_en = eff_mask[gp][RIMB_SLOT_CODE][3];

      // T1 layout
      wire logic spare_code_clear_en = eff_mask[gp][RIMB_SLOT_CODE][6];
      wire logic loop_down_clear_en = eff_mask[gp][RIMB_SLOT_CODE][5];
      wire logic loop_up_clear_en = eff_mask[gp][RIMB_SLOT_CODE][4];
      wire logic spare_code_detect_en = eff_mask[gp][RIMB_SLOT_CODE][2];
      wire logic loop_down_detect_en = eff_mask[gp][RIMB_SLOT_CODE][1];
      wire logic loop_up_detect_en = eff_mask[gp][RIMB_SLOT_CODE][0];

      // E1 layout
      wire logic v52_link_clear_en = eff_mask[gp][RIMB_SLOT_CODE][5];
      wire logic distant_mf_alarm_clear_en = eff_mask[gp][RIMB_SLOT_CODE][4];
      wire logic v52_link_detect_en = eff_mask[gp][RIMB_SLOT_CODE][1];
      wire logic distant_mf_alarm_detect_en = eff_mask[gp][RIMB_SLOT_CODE][0];

      // --------------------------------------------------------------
      // Elastic store and timer enables
      // --------------------------------------------------------------
      wire logic elastic_full_en = eff_mask[gp][RIMB_SLOT_STORE][7];
      wire logic elastic_empty_en = eff_mask[gp][RIMB_SLOT_STORE][6];
      wire logic elastic_slip_en = eff_mask[gp][RIMB_SLOT_STORE][5];
      wire logic sig_change_en = eff_mask[gp][RIMB_SLOT_STORE][3];
      wire logic one_second_tick_en = eff_mask[gp][RIMB_SLOT_STORE][2];
      wire logic timer_event_en = eff_mask[gp][RIMB_SLOT_STORE][1];
      wire logic multiframe_event_en = eff_mask[gp][RIMB_SLOT_STORE][0];

      // --------------------------------------------------------------
      // HDLC enables
      // --------------------------------------------------------------
      wire logic hdlc_fifo_overrun_en = eff_mask[gp][RIMB_SLOT_HDLC][5];
      wire logic hdlc_opening_byte_en = eff_mask[gp][RIMB_SLOT_HDLC][4];
      wire logic packet_end_en = eff_mask[gp][RIMB_SLOT_HDLC][3];
      wire logic packet_start_en = eff_mask[gp][RIMB_SLOT_HDLC][2];
      wire logic fifo_high_watermark_en = eff_mask[gp][RIMB_SLOT_HDLC][1];
      wire logic fifo_not_empty_en = eff_mask[gp][RIMB_SLOT_HDLC][0];

      // --------------------------------------------------------------
      // T1 datalink enables
      // --------------------------------------------------------------
      wire logic remote_alarm_ci_en = eff_mask[gp][RIMB_SLOT_DLINK][5];
      wire logic alarm_signal_ci_en = eff_mask[gp][RIMB_SLOT_DLINK][4];
      wire logic subscriber_carrier_event_en = eff_mask[gp][RIMB_SLOT_DLINK][3];
      wire logic datalink_reg_full_en = eff_mask[gp][RIMB_SLOT_DLINK][2];
      wire logic boc_clear_en = eff_mask[gp][RIMB_SLOT_DLINK][1];
      wire logic boc_detect_en = eff_mask[gp][RIMB_SLOT_DLINK][0];

      // --------------------------------------------------------------
      // Enable vectors in status bit order
      // --------------------------------------------------------------
      logic [7:0] en_alarm;
      logic [7:0] en_frame;
      logic [7:0] en_code_t1;
      logic [7:0] en_code_e1;
      logic [7:0] en_code;
      logic [7:0] en_store;
      logic [7:0] en_hdlc;
      logic [7:0] en_dlink;

      assign en_alarm = {4'h0, remote_alarm_detect_en, alarm_signal_detect_en,
                         signal_loss_detect_en, frame_loss_detect_en};
      assign en_frame = {4'h0, sig_all_ones_en, sig_all_zeros_en,
                         crc4_multiframe_en, align_frame_en};
      assign en_code_t1 = {rx_clock_loss_clear_en, spare_code_clear_en,
                           loop_down_clear_en, loop_up_clear_en,
                           rx_clock_loss_detect_en, spare_code_detect_en,
                           loop_down_detect_en, loop_up_detect_en};
      assign en_code_e1 = {rx_clock_loss_clear_en, 1'b0,
                           v52_link_clear_en, distant_mf_alarm_clear_en,
                           rx_clock_loss_detect_en, 1'b0,
                           v52_link_detect_en, distant_mf_alarm_detect_en};
      assign en_code = e1_mode[gp] ? en_code_e1 : en_code_t1;
      assign en_store = {elastic_full_en, elastic_empty_en, elastic_slip_en, 1'b0,
                         sig_change_en, one_second_tick_en, timer_event_en,
                         multiframe_event_en};
      assign en_hdlc = {2'h0, hdlc_fifo_overrun_en, hdlc_opening_byte_en,
                        packet_end_en, packet_start_en,
                        fifo_high_watermark_en, fifo_not_empty_en};
      assign en_dlink = {2'h0, remote_alarm_ci_en, alarm_signal_ci_en,
                         subscriber_carrier_event_en, datalink_reg_full_en,
                         boc_clear_en, boc_detect_en};

      // --------------------------------------------------------------
      // Gating of latched events
      // --------------------------------------------------------------
      logic [7:0] hit_alarm;
      logic [7:0] hit_frame;
      logic [7:0] hit_code;
      logic [7:0] hit_store;
      logic [7:0] hit_hdlc;
      logic [7:0] hit_dlink;

      assign hit_alarm = rx_status[gp].alarm & en_alarm;
      assign hit_frame = rx_status[gp].frame & en_frame;
      assign hit_code = rx_status[gp].code & en_code;
      assign hit_store = rx_status[gp].store & en_store;
      assign hit_hdlc = rx_status[gp].hdlc & en_hdlc;
      assign hit_dlink = rx_status[gp].dlink & en_dlink;

      // Summary bit per status register; bits 7 and 5 have no source
      assign nxt_summary[gp] = {1'b0, |hit_dlink, 1'b0, |hit_hdlc,
                                |hit_store, |hit_code, |hit_frame,
                                |hit_alarm};
      assign port_pending[gp] = |nxt_summary[gp];
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   assign nxt_int_n = ~(|port_pending);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_n_ff <= RIMB_INT_IDLE;
      end else begin
         int_n_ff <= nxt_int_n;
      end
   end

   // ----------------------------------------------------------------
   // Summary output
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         summary_ff <= {RIMB_PORTS{RIMB_SUMMARY_RST}};
      end else begin
         summary_ff <= nxt_summary;
      end
   end

   assign interrupt_out_n = int_n_ff;
   assign rx_interrupt_summary = summary_ff;

endmodule : rimb_mask_bank

`default_nettype wire

// [logic/rimb_pkg.sv]
// Package for the receive interrupt mask bank: map, field layouts, reset values, decode
package rimb_pkg;

   // ----------------------------------------------------------------
   // Bank geometry
   // ----------------------------------------------------------------
   localparam int RIMB_PORTS = 4;
   localparam int RIMB_SLOTS = 6;
   localparam int RIMB_PORT_LSB = 9;
   localparam logic [13:0] RIMB_PORT_STRIDE = 14'h0200;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the sum of index and port times port stride)
   // ----------------------------------------------------------------
   localparam logic [8:0] RIMB_IDX_ALARM = 9'h0A0;
   localparam logic [8:0] RIMB_IDX_FRAME = 9'h0A1;
   localparam logic [8:0] RIMB_IDX_CODE = 9'h0A2;
   localparam logic [8:0] RIMB_IDX_STORE = 9'h0A3;
   localparam logic [8:0] RIMB_IDX_HDLC = 9'h0A4;
   localparam logic [8:0] RIMB_IDX_DLINK = 9'h0A6;

   // ----------------------------------------------------------------
   // Storage slots
   // ----------------------------------------------------------------
   localparam logic [2:0] RIMB_SLOT_ALARM = 3'h0;
   localparam logic [2:0] RIMB_SLOT_FRAME = 3'h1;
   localparam logic [2:0] RIMB_SLOT_CODE = 3'h2;
   localparam logic [2:0] RIMB_SLOT_STORE = 3'h3;
   localparam logic [2:0] RIMB_SLOT_HDLC = 3'h4;
   localparam logic [2:0] RIMB_SLOT_DLINK = 3'h5;

   // ----------------------------------------------------------------
   // Implemented bits per register and mode
   // ----------------------------------------------------------------
   localparam logic [7:0] RIMB_VALID_NONE = 8'h00;
   localparam logic [7:0] RIMB_VALID_ALARM = 8'h0F;
   localparam logic [7:0] RIMB_VALID_FRAME_E1 = 8'h0F;
   localparam logic [7:0] RIMB_VALID_CODE_T1 = 8'hFF;
   localparam logic [7:0] RIMB_VALID_CODE_E1 = 8'hBB;
   localparam logic [7:0] RIMB_VALID_STORE = 8'hEF;
   localparam logic [7:0] RIMB_VALID_HDLC = 8'h3F;
   localparam logic [7:0] RIMB_VALID_DLINK_T1 = 8'h3F;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RIMB_MASK_RST = 8'h00;
   localparam logic [7:0] RIMB_SUMMARY_RST = 8'h00;
   localparam logic RIMB_INT_IDLE = 1'b1;
   localparam logic [31:0] RIMB_RDATA_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] dlink;
      logic [7:0] hdlc;
      logic [7:0] store;
      logic [7:0] code;
      logic [7:0] frame;
      logic [7:0] alarm;
   } rimb_regs_t;

   typedef struct packed {
      logic hit;
      logic [1:0] port;
      logic [2:0] slot;
   } rimb_access_t;

   typedef struct packed {
      logic valid;
      logic [1:0] port;
      logic [2:0] slot;
      logic [7:0] data;
   } rimb_write_t;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic rimb_access_t rimb_decode(input logic [15:0] addr);
      rimb_access_t acc;
      logic [13:0] idx;
      idx = addr[15:2];
      acc = '0;
      acc.port = idx[RIMB_PORT_LSB+1:RIMB_PORT_LSB];
      if (addr[1:0] == 2'h0 && idx[13:11] == 3'h0) begin
         acc.hit = 1'b1;
         case (idx[8:0])
            RIMB_IDX_ALARM: acc.slot = RIMB_SLOT_ALARM;
            RIMB_IDX_FRAME: acc.slot = RIMB_SLOT_FRAME;
            RIMB_IDX_CODE: acc.slot = RIMB_SLOT_CODE;
            RIMB_IDX_STORE: acc.slot = RIMB_SLOT_STORE;
            RIMB_IDX_HDLC: acc.slot = RIMB_SLOT_HDLC;
            RIMB_IDX_DLINK: acc.slot = RIMB_SLOT_DLINK;
            default: acc.hit = 1'b0;
         endcase
      end
      return acc;
   endfunction : rimb_decode

   // ----------------------------------------------------------------
   // Implemented bits of one slot in the current mode
   // ----------------------------------------------------------------
   function automatic logic [7:0] rimb_valid_bits(input logic [2:0] slot, input logic e1);
      logic [7:0] v;
      case (slot)
         RIMB_SLOT_ALARM: v = RIMB_VALID_ALARM;
         RIMB_SLOT_FRAME: v = e1 ? RIMB_VALID_FRAME_E1 : RIMB_VALID_NONE;
         RIMB_SLOT_CODE: v = e1 ? RIMB_VALID_CODE_E1 : RIMB_VALID_CODE_T1;
         RIMB_SLOT_STORE: v = RIMB_VALID_STORE;
         RIMB_SLOT_HDLC: v = RIMB_VALID_HDLC;
         RIMB_SLOT_DLINK: v = e1 ? RIMB_VALID_NONE : RIMB_VALID_DLINK_T1;
         default: v = RIMB_VALID_NONE;
      endcase
      return v;
   endfunction : rimb_valid_bits

endpackage : rimb_pkg
